// ===== adsq_regs.svh
// Register offsets, field positions, reset values and counts of the scan range sequencer
`ifndef ADSQ_REGS_SVH
`define ADSQ_REGS_SVH
`define ADSQ_OFS_TRIGGER 4'h0
`define ADSQ_OFS_RANGE 4'h1
`define ADSQ_OFS_SCAN 4'h2
`define ADSQ_RANGE_LSB 0
`define ADSQ_RANGE_MSB 3
`define ADSQ_START_LSB 0
`define ADSQ_START_MSB 3
`define ADSQ_STOP_LSB 4
`define ADSQ_STOP_MSB 7
`define ADSQ_CHAN_RST 4'h0
`define ADSQ_CODE_RST 4'h0
`define ADSQ_RDATA_RST 8'h00
`define ADSQ_NUM_CH 16
`endif

// ===== adsq_pkg.sv
// Types shared by the scan range sequencer modules
package adsq_pkg;
	typedef logic [3:0] adsq_chan_t;
	typedef logic [3:0] adsq_code_t;
	typedef logic [7:0] adsq_byte_t;
	typedef logic [3:0] adsq_ofs_t;
	// Polarity class of a range code
	typedef enum logic [1:0] {
		ADSQ_POL_BIPOLAR = 2'h0,
		ADSQ_POL_UNIPOLAR = 2'h1,
		ADSQ_POL_UNUSED = 2'h3
	} adsq_pol_e;
endpackage : adsq_pkg

// ===== adsq_ram_if.sv
// Carrier between the sequencer control and its range code RAM
interface adsq_ram_if;
	import adsq_pkg::*;
	logic wr_en;
	adsq_chan_t wr_addr;
	adsq_code_t wr_data;
	adsq_chan_t rd_addr;
	adsq_code_t rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : adsq_ram_if

// ===== adsq_range_ram.sv
// Per-channel range code store with a write-through read port
`include "adsq_regs.svh"
module adsq_range_ram #(
	parameter int NUM_CH = `ADSQ_NUM_CH
) (
	input wire logic mclk_i, // System clock
	input wire logic rst_n_i, // Asynchronous reset, active low
	adsq_ram_if.mem ram // Write and read port
);
	import adsq_pkg::*;

	adsq_code_t mem_q [NUM_CH];
	adsq_code_t next_mem [NUM_CH];

	// Write port: only the addressed entry changes
	always_comb begin
		next_mem = mem_q;
		if (ram.wr_en) begin
			next_mem[ram.wr_addr] = ram.wr_data;
		end
	end

	// Entries cleared at reset; generated per entry
	for (genvar g = 0; g < NUM_CH; g++) begin : g_entry
		always_ff @(posedge mclk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				mem_q[g] <= `ADSQ_CODE_RST;
			end else begin
				mem_q[g] <= next_mem[g];
			end
		end
	end

	// Read forwards a write to the same entry so no stale code is seen
	assign ram.rd_data = (ram.wr_en && ram.wr_addr == ram.rd_addr) ? ram.wr_data
		: mem_q[ram.rd_addr];
endmodule : adsq_range_ram

// ===== adsq_sequencer.sv
// Scan range sequencer: range code RAM, scan window and current channel
// Operation
// - Each channel keeps its own range code; conversions use the current channel's code.
// - Range port write stores bits 3..0 as range code; upper bits ignored.
// - Range code lands in the entry named by the start channel nibble.
// - Standard variant: 0-3 bipolar, 4-7 unipolar, 8 bipolar, rest unused.
// - High-gain variant: 0-3 bipolar, 4-7 unipolar, 8-11 bipolar, rest unused.
// - Scan port write latches stop from bits 7..4 and start from 3..0.
// - Every scan port write loads the current channel with the new start.
// - Each conversion trigger in a cycle without a scan port write advances the current channel once.
// - Channel steps start to stop, then returns to start, forever.
// - Scan port read returns the current channel in bits 3..0.
// - With software triggering, any write to the trigger port starts a conversion.
`include "adsq_regs.svh"
module adsq_sequencer #(
	parameter bit HIGH_GAIN = 1'b0, // Selects the high-gain range table
	parameter int NUM_CH = `ADSQ_NUM_CH // Channels behind the multiplexer
) (
	input wire logic mclk_i, // System clock, 25 MHz
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire adsq_pkg::adsq_ofs_t io_addr_i, // Byte port offset
	input wire adsq_pkg::adsq_byte_t io_wdata_i, // Write data
	input wire logic io_wr_i, // Write strobe, one cycle
	input wire logic io_rd_i, // Read strobe, one cycle
	input wire logic sw_trig_sel_i, // High: software trigger selected
	input wire logic ext_trig_i, // Pacer or external trigger pulse
	output logic [7:0] io_rdata_o, // Read data, valid cycle after io_rd_i
	output adsq_pkg::adsq_chan_t mux_channel_o, // Current multiplexer channel
	output adsq_pkg::adsq_code_t range_code_o, // Range code of current channel
	output logic range_unipolar_o, // Current code is a unipolar range
	output logic range_valid_o, // Current code is a defined range
	output logic conv_start_o // One-cycle conversion start pulse
);
	import adsq_pkg::*;

	if (NUM_CH != 16) begin : g_check
		$error("adsq_sequencer serves exactly 16 channels");
	end

	adsq_ram_if ram ();

	adsq_range_ram #(
		.NUM_CH(NUM_CH)
	) u_ram (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.ram(ram.mem)
	);

	// Polarity class of a code for the selected variant
	function automatic adsq_pol_e code_class(input adsq_code_t code);
		adsq_pol_e pol;
		pol = ADSQ_POL_UNUSED;
		case (code[3:2])
			2'h0: pol = ADSQ_POL_BIPOLAR;
			2'h1: pol = ADSQ_POL_UNIPOLAR;
			2'h2: pol = (HIGH_GAIN || code[1:0] == 2'h0) ? ADSQ_POL_BIPOLAR
				: ADSQ_POL_UNUSED;
			default: pol = ADSQ_POL_UNUSED;
		endcase
		return pol;
	endfunction : code_class

	// Port write decode, used for every write register; strobe and offset are arguments
	// so that continuous assignments see every change of them
	function automatic logic wr_hit(input logic wr, input adsq_ofs_t addr,
		input adsq_ofs_t ofs);
		return wr && addr == ofs;
	endfunction : wr_hit

	adsq_chan_t start_ch;
	adsq_chan_t stop_ch;
	adsq_chan_t cur_ch;
	adsq_chan_t next_start_ch;
	adsq_chan_t next_stop_ch;
	adsq_chan_t next_cur_ch;
	logic trig;
	logic scan_wr;
	logic next_conv_start;
	logic [7:0] next_rdata;
	adsq_code_t next_code;
	adsq_pol_e next_pol;

	// Trigger source and scan write strobe
	assign scan_wr = wr_hit(io_wr_i, io_addr_i, `ADSQ_OFS_SCAN);
	assign trig = sw_trig_sel_i ? wr_hit(io_wr_i, io_addr_i, `ADSQ_OFS_TRIGGER)
		: ext_trig_i;

	// Scan window and channel stepping; a scan write wins over a trigger
	always_comb begin
		next_start_ch = start_ch;
		next_stop_ch = stop_ch;
		next_cur_ch = cur_ch;
		if (scan_wr) begin
			next_stop_ch = io_wdata_i[`ADSQ_STOP_MSB:`ADSQ_STOP_LSB];
			next_start_ch = io_wdata_i[`ADSQ_START_MSB:`ADSQ_START_LSB];
			next_cur_ch = io_wdata_i[`ADSQ_START_MSB:`ADSQ_START_LSB];
		end else if (trig) begin
			if (cur_ch == stop_ch) begin
				next_cur_ch = start_ch;
			end else begin
				next_cur_ch = adsq_chan_t'(cur_ch + 4'h1);
			end
		end
	end

	// Range RAM write at the start channel, read at the coming channel
	always_comb begin
		ram.wr_en = wr_hit(io_wr_i, io_addr_i, `ADSQ_OFS_RANGE);
		ram.wr_addr = start_ch;
		ram.wr_data = io_wdata_i[`ADSQ_RANGE_MSB:`ADSQ_RANGE_LSB];
		ram.rd_addr = next_cur_ch;
	end

	// Output values for the next cycle
	always_comb begin
		next_code = ram.rd_data;
		next_pol = code_class(ram.rd_data);
		next_conv_start = trig;
		next_rdata = `ADSQ_RDATA_RST;
		if (io_rd_i && io_addr_i == `ADSQ_OFS_SCAN) begin
			next_rdata = {4'h0, cur_ch};
		end
	end

	// State and output registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_ch <= `ADSQ_CHAN_RST;
			stop_ch <= `ADSQ_CHAN_RST;
			cur_ch <= `ADSQ_CHAN_RST;
			mux_channel_o <= `ADSQ_CHAN_RST;
			range_code_o <= `ADSQ_CODE_RST;
			range_unipolar_o <= 1'b0;
			range_valid_o <= 1'b1;
			conv_start_o <= 1'b0;
			io_rdata_o <= `ADSQ_RDATA_RST;
		end else begin
			start_ch <= next_start_ch;
			stop_ch <= next_stop_ch;
			cur_ch <= next_cur_ch;
			mux_channel_o <= next_cur_ch;
			range_code_o <= next_code;
			range_unipolar_o <= (next_pol == ADSQ_POL_UNIPOLAR);
			range_valid_o <= (next_pol != ADSQ_POL_UNUSED);
			conv_start_o <= next_conv_start;
			io_rdata_o <= next_rdata;
		end
	end

	// Checks on channel stepping and register effects
	property p_scan_load;
		@(posedge mclk_i) disable iff (!rst_n_i)
		scan_wr |=> mux_channel_o == $past(io_wdata_i[3:0]) && stop_ch == $past(io_wdata_i[7:4]);
	endproperty
	a_scan_load: assert property (p_scan_load) else $error("scan write did not load window");
	property p_window;
		@(posedge mclk_i) disable iff (!rst_n_i)
		scan_wr ##1 (!scan_wr && !trig)[*2] |-> start_ch == $past(io_wdata_i[3:0], 2);
	endproperty
	a_window: assert property (p_window) else $error("start channel not held");
	property p_step;
		@(posedge mclk_i) disable iff (!rst_n_i)
		trig && !scan_wr && cur_ch != stop_ch |=> cur_ch == 4'($past(cur_ch) + 4'h1);
	endproperty
	a_step: assert property (p_step) else $error("trigger did not step channel");
	property p_wrap;
		@(posedge mclk_i) disable iff (!rst_n_i)
		trig && !scan_wr && cur_ch == stop_ch |=> cur_ch == $past(start_ch);
	endproperty
	a_wrap: assert property (p_wrap) else $error("stop channel did not return to start");
	property p_mod16;
		@(posedge mclk_i) disable iff (!rst_n_i)
		trig && !scan_wr && cur_ch == 4'hF && stop_ch != 4'hF |=> mux_channel_o == 4'h0;
	endproperty
	a_mod16: assert property (p_mod16) else $error("channel did not wrap to zero");
	property p_hold;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!trig && !scan_wr |=> $stable(mux_channel_o);
	endproperty
	a_hold: assert property (p_hold) else $error("channel moved without cause");
	property p_read;
		@(posedge mclk_i) disable iff (!rst_n_i)
		io_rd_i && io_addr_i == `ADSQ_OFS_SCAN |=> io_rdata_o == {4'h0, $past(cur_ch)};
	endproperty
	a_read: assert property (p_read) else $error("scan read returned wrong channel");
	property p_range_wr;
		@(posedge mclk_i) disable iff (!rst_n_i)
		io_wr_i && io_addr_i == `ADSQ_OFS_RANGE |-> ram.wr_en && ram.wr_addr == start_ch
			&& ram.wr_data == io_wdata_i[3:0];
	endproperty
	a_range_wr: assert property (p_range_wr) else $error("range write misdirected");
	property p_code_use;
		@(posedge mclk_i) disable iff (!rst_n_i)
		1'b1 |=> range_code_o == $past(ram.rd_data) && mux_channel_o == $past(ram.rd_addr);
	endproperty
	a_code_use: assert property (p_code_use) else $error("range code not of current channel");
	property p_pol;
		@(posedge mclk_i) disable iff (!rst_n_i)
		range_unipolar_o == (range_code_o[3:2] == 2'h1);
	endproperty
	a_pol: assert property (p_pol) else $error("unipolar flag wrong for code");
	property p_sw_trig;
		@(posedge mclk_i) disable iff (!rst_n_i)
		sw_trig_sel_i && io_wr_i && io_addr_i == `ADSQ_OFS_TRIGGER |=> conv_start_o;
	endproperty
	a_sw_trig: assert property (p_sw_trig) else $error("software trigger lost");
	property p_valid;
		@(posedge mclk_i) disable iff (!rst_n_i)
		range_valid_o == (HIGH_GAIN ? (range_code_o <= 4'hB) : (range_code_o <= 4'h8));
	endproperty
	a_valid: assert property (p_valid) else $error("defined range flag wrong for code");
	property p_ext_trig;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!sw_trig_sel_i && ext_trig_i |=> conv_start_o;
	endproperty
	a_ext_trig: assert property (p_ext_trig) else $error("external trigger lost");
	property p_no_trig;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!sw_trig_sel_i && !ext_trig_i |=> !conv_start_o;
	endproperty
	a_no_trig: assert property (p_no_trig) else $error("conversion start without trigger");
endmodule : adsq_sequencer

// ===== adsq_host_model.sv
// Host software model driving the byte I/O port of the sequencer
module adsq_host_model (
	input wire logic mclk_i, // System clock
	output adsq_pkg::adsq_ofs_t io_addr_o, // Port offset
	output adsq_pkg::adsq_byte_t io_wdata_o, // Write data
	output logic io_wr_o, // Write strobe
	output logic io_rd_o, // Read strobe
	input wire logic [7:0] io_rdata_i // Read data
);
	timeunit 1ns;
	timeprecision 100ps;
	import adsq_pkg::*;
	// Idle bus at time zero
	initial begin
		io_addr_o = 4'hF;
		io_wdata_o = 8'hFF;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
	end
	// One byte write; afterwards the released bus shows inverted values
	task automatic wr(input adsq_ofs_t a, input adsq_byte_t d);
		@(posedge mclk_i);
		io_addr_o <= a;
		io_wdata_o <= d;
		io_wr_o <= 1'b1;
		@(posedge mclk_i);
		io_wr_o <= 1'b0;
		io_addr_o <= ~a;
		io_wdata_o <= ~d;
	endtask : wr
	// One byte read; data is taken in the cycle after the read edge
	task automatic rd(input adsq_ofs_t a, output adsq_byte_t d);
		@(posedge mclk_i);
		io_addr_o <= a;
		io_rd_o <= 1'b1;
		@(posedge mclk_i);
		io_rd_o <= 1'b0;
		io_addr_o <= ~a;
		#1;
		d = io_rdata_i;
	endtask : rd
endmodule : adsq_host_model

// ===== adc_scan_range_sequencer_bench.sv
// Self-checking bench of the scan range sequencer
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module adc_scan_range_sequencer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import adsq_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic sw_sel = 1'b0;
	logic ext_trig = 1'b0;
	adsq_ofs_t io_addr;
	adsq_byte_t io_wdata;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_rdata;
	adsq_chan_t mux_ch;
	adsq_code_t range_code;
	logic unip;
	logic valid;
	logic conv_start;
	logic valid_hg;
	int failures = 0;
	int n_checks = 0;
	// 25 MHz clock
	initial begin
		forever #20 mclk = ~mclk;
	end
	adsq_host_model host (.mclk_i(mclk), .io_addr_o(io_addr), .io_wdata_o(io_wdata),
		.io_wr_o(io_wr), .io_rd_o(io_rd), .io_rdata_i(io_rdata));
	adsq_sequencer #(.HIGH_GAIN(1'b0), .NUM_CH(16)) dut (.mclk_i(mclk), .rst_n_i(rst_n),
		.io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_wr_i(io_wr), .io_rd_i(io_rd),
		.sw_trig_sel_i(sw_sel), .ext_trig_i(ext_trig), .io_rdata_o(io_rdata),
		.mux_channel_o(mux_ch), .range_code_o(range_code), .range_unipolar_o(unip),
		.range_valid_o(valid), .conv_start_o(conv_start));
	// High-gain variant on the same bus, judged on its defined range flag
	adsq_sequencer #(.HIGH_GAIN(1'b1), .NUM_CH(16)) dut_hg (.mclk_i(mclk), .rst_n_i(rst_n),
		.io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_wr_i(io_wr), .io_rd_i(io_rd),
		.sw_trig_sel_i(sw_sel), .ext_trig_i(ext_trig), .io_rdata_o(),
		.mux_channel_o(), .range_code_o(), .range_unipolar_o(),
		.range_valid_o(valid_hg), .conv_start_o());
	// Counts, verdict and end of run
	task automatic print_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	// Scan window write, then channel output and scan port readback
	task automatic scan(input adsq_byte_t d);
		adsq_byte_t r;
		host.wr(4'h2, d);
		@(posedge mclk);
		#1;
		`CHK("mux_ch", d[3:0], mux_ch)
		host.rd(4'h2, r);
		`CHK("scan_rd", {4'h0, d[3:0]}, r)
	endtask : scan
	// External trigger; every channel holds its own number as range code
	task automatic trig(input adsq_chan_t ch);
		@(posedge mclk);
		ext_trig <= 1'b1;
		@(posedge mclk);
		ext_trig <= 1'b0;
		#1;
		`CHK("conv_start", 1'b1, conv_start)
		`CHK("mux_ch", ch, mux_ch)
		`CHK("range_code", ch, range_code)
		`CHK("unipolar", ch[3:2] == 2'h1, unip)
		`CHK("valid", ch <= 4'h8, valid)
		`CHK("valid_hg", ch <= 4'hB, valid_hg)
	endtask : trig
	// Reset state and a read of the range port offset
	task automatic t_reset;
		adsq_byte_t r;
		host.rd(4'h2, r);
		`CHK("scan_rd", 8'h00, r)
		`CHK("mux_ch", 4'h0, mux_ch)
		`CHK("range_code", 4'h0, range_code)
		`CHK("unipolar", 1'b0, unip)
		`CHK("valid", 1'b1, valid)
		`CHK("conv_start", 1'b0, conv_start)
		host.rd(4'h1, r);
		`CHK("range_rd", 8'h00, r)
		$display("test reset done");
	endtask : t_reset
	// Range codes for all sixteen channels, upper nibble noisy
	task automatic t_program;
		for (int i = 0; i < 16; i++) begin
			host.wr(4'h2, {4'hF, 4'(i)});
			host.wr(4'h1, {~4'(i), 4'(i)});
			@(posedge mclk);
			#1;
			`CHK("range_code", 4'(i), range_code)
		end
		$display("test program done");
	endtask : t_program
	// Plain window and a window that wraps through fifteen
	task automatic t_scan;
		scan(8'h73);
		trig(4'h4);
		trig(4'h5);
		trig(4'h6);
		trig(4'h7);
		trig(4'h3);
		scan(8'h2E);
		trig(4'hF);
		trig(4'h0);
		trig(4'h1);
		trig(4'h2);
		trig(4'hE);
		$display("test scan done");
	endtask : t_scan
	// Software trigger port, honoured only when selected
	task automatic t_sw;
		scan(8'h31);
		@(posedge mclk);
		sw_sel <= 1'b1;
		host.wr(4'h0, 8'h5A);
		#1;
		`CHK("conv_start", 1'b1, conv_start)
		`CHK("mux_ch", 4'h2, mux_ch)
		@(posedge mclk);
		sw_sel <= 1'b0;
		host.wr(4'h0, 8'hA5);
		#1;
		`CHK("conv_start", 1'b0, conv_start)
		`CHK("mux_ch", 4'h2, mux_ch)
		$display("test sw trigger done");
	endtask : t_sw
	// Reset in mid-run clears window, channel and stored codes, checked on channels 0 and 5
	task automatic t_rerst;
		scan(8'h95);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		`CHK("mux_ch", 4'h0, mux_ch)
		`CHK("range_code", 4'h0, range_code)
		`CHK("valid", 1'b1, valid)
		trig(4'h0);
		scan(8'h55);
		`CHK("range_code", 4'h0, range_code)
		$display("test mid-run reset done");
	endtask : t_rerst
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_program();
		t_scan();
		t_sw();
		t_rerst();
		print_verdict();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		print_verdict();
	end
endmodule : adc_scan_range_sequencer_bench
